// File: rtl/rbd_pkg.sv
// Constants for the relative branch and single bit set execute block
package rbd_pkg;

   // ==========================================================
   // Widths
   localparam int PC_W = 21;
   localparam int DA_W = 12;
   localparam int BANK_W = 4;
   localparam int OFF_W = 11;

   // ==========================================================
   // Opcode fields
   localparam logic [3:0] OP_NIB_BRANCH = 4'hd;
   localparam logic [3:0] OP_NIB_BITSET = 4'h8;
   localparam logic [7:0] OP_BYTE_BNZ = 8'he1;
   localparam int NIB_HI = 15;
   localparam int NIB_LO = 12;
   localparam int BRA_SEL_BIT = 11;
   localparam int BIT_IDX_HI = 11;
   localparam int BIT_IDX_LO = 9;
   localparam int ACCESS_BIT = 8;

   // ==========================================================
   // Access bank split and indexed literal limit
   localparam logic [7:0] ACCESS_LOW_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

   // ==========================================================
   // Reset values
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [DA_W-1:0] ADDR_RESET = 12'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [15:0] INSTR_RESET = 16'h0000;

   // ==========================================================
   // Four-phase instruction cycle, one-hot
   typedef enum logic [3:0]
   {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } rbd_phase_e;

   // Kind of instruction held for execution, one-hot
   typedef enum logic [3:0]
   {
      K_NONE = 4'h1,
      K_BRA = 4'h2,
      K_BNZ = 4'h4,
      K_BSF = 4'h8
   } rbd_kind_e;

endpackage

// File: rtl/rbd_exec.sv
// Execute unit for relative branches and the single bit set instruction
// Notes on behaviour
// - Top nibble 1101 with bit 11 clear is a branch; low 11 bits signed offset.
// - Branch loads incremented address plus twice offset; two cycles, second idle, flags kept.
// - Bit set forces indexed bit of addressed register high, others and flags kept.
// - Access bit 0 selects access bank; access bit 1 uses bank select register.
// - Access bit 0, extended set on, address up to 5Fh: indexed literal offset.
// - Opcode E1h branches by twice 8-bit offset only when zero flag is clear.
// - Conditional branch takes one cycle untaken, two taken, flushing prefetched word.
`timescale 1ns/1ps

module rbd_exec
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [rbd_pkg::PC_W-1:0] pc_incr,
   input wire logic zero_flag,
   input wire logic ext_set_enable,
   input wire logic [rbd_pkg::BANK_W-1:0] bank_select_register,
   input wire logic [rbd_pkg::DA_W-1:0] literal_base,
   input wire logic [7:0] data_rdata,
   output logic instr_take,
   output logic cycle_start,
   output logic [rbd_pkg::PC_W-1:0] program_counter_target,
   output logic program_counter_load,
   output logic flush_active,
   output logic [rbd_pkg::DA_W-1:0] data_addr,
   output logic data_rd,
   output logic data_wr,
   output logic [7:0] data_wdata
);

   // ==========================================================
   // Helpers
   // Incremented address plus twice a signed word offset
   function automatic logic [rbd_pkg::PC_W-1:0] branch_target
   (
      input logic [rbd_pkg::PC_W-1:0] base,
      input logic [rbd_pkg::OFF_W-1:0] off
   );
      logic [rbd_pkg::PC_W-1:0] ext;
      ext = {{(rbd_pkg::PC_W-rbd_pkg::OFF_W-1){off[rbd_pkg::OFF_W-1]}}, off, 1'b0};
      return base + ext;
   endfunction

   // Sign extend an 8-bit offset to the branch offset width
   function automatic logic [rbd_pkg::OFF_W-1:0] widen_off(input logic [7:0] off);
      return {{(rbd_pkg::OFF_W-8){off[7]}}, off};
   endfunction

   // ==========================================================
   // State
   rbd_pkg::rbd_phase_e phase;
   rbd_pkg::rbd_phase_e next_phase;
   rbd_pkg::rbd_kind_e kind;
   rbd_pkg::rbd_kind_e next_kind;
   logic [15:0] held_instr;
   logic [15:0] next_held_instr;
   logic [rbd_pkg::PC_W-1:0] held_pc;
   logic [rbd_pkg::PC_W-1:0] next_held_pc;
   logic held_zero;
   logic next_held_zero;
   logic flush_pending;
   logic next_flush_pending;
   logic [7:0] read_value;
   logic [7:0] next_read_value;
   logic [rbd_pkg::PC_W-1:0] next_program_counter_target;
   logic next_program_counter_load;
   logic next_flush_active;
   logic [rbd_pkg::DA_W-1:0] next_data_addr;
   logic next_data_rd;
   logic next_data_wr;
   logic [7:0] next_data_wdata;

   // Decoded fields of the incoming word
   logic [3:0] in_nib;
   logic [7:0] in_f;
   logic in_access;
   rbd_pkg::rbd_kind_e in_kind;
   logic [rbd_pkg::DA_W-1:0] in_addr;
   logic [7:0] set_mask;

   assign in_nib = instr[rbd_pkg::NIB_HI:rbd_pkg::NIB_LO];
   assign in_f = instr[7:0];
   assign in_access = instr[rbd_pkg::ACCESS_BIT];

   // Handshake outputs: new word taken only in Q1 outside a flush cycle
   assign cycle_start = (phase == rbd_pkg::PH_Q1);
   assign instr_take = cycle_start && !flush_active && instr_valid;

   // ==========================================================
   // Opcode decode
   always_comb
   begin
      in_kind = rbd_pkg::K_NONE;
      if (in_nib == rbd_pkg::OP_NIB_BRANCH && !instr[rbd_pkg::BRA_SEL_BIT])
      begin
         in_kind = rbd_pkg::K_BRA;
      end
      else if (instr[15:8] == rbd_pkg::OP_BYTE_BNZ)
      begin
         in_kind = rbd_pkg::K_BNZ;
      end
      else if (in_nib == rbd_pkg::OP_NIB_BITSET)
      begin
         in_kind = rbd_pkg::K_BSF;
      end
   end

   // ==========================================================
   // Data address formation for the bit set
   always_comb
   begin
      if (in_access)
      begin
         in_addr = {bank_select_register, in_f};
      end
      else if (ext_set_enable && in_f <= rbd_pkg::ACCESS_LOW_MAX)
      begin
         // Base comes from the core's pointer; wraps at 4K
         in_addr = literal_base + {4'h0, in_f};
      end
      else if (in_f <= rbd_pkg::ACCESS_LOW_MAX)
      begin
         in_addr = {rbd_pkg::ACCESS_LOW_BANK, in_f};
      end
      else
      begin
         in_addr = {rbd_pkg::ACCESS_HIGH_BANK, in_f};
      end
   end

   // One-hot mask for the selected bit
   assign set_mask = 8'h01 << held_instr[rbd_pkg::BIT_IDX_HI:rbd_pkg::BIT_IDX_LO];

   // ==========================================================
   // Next state: phases advance every clock, work keyed to phase
   always_comb
   begin
      next_phase = phase;
      next_kind = kind;
      next_held_instr = held_instr;
      next_held_pc = held_pc;
      next_held_zero = held_zero;
      next_flush_pending = flush_pending;
      next_read_value = read_value;
      next_program_counter_target = program_counter_target;
      next_program_counter_load = 1'b0;
      next_flush_active = flush_active;
      next_data_addr = data_addr;
      next_data_rd = 1'b0;
      next_data_wr = 1'b0;
      next_data_wdata = data_wdata;
      case (phase)
         rbd_pkg::PH_Q1:
         begin
            next_phase = rbd_pkg::PH_Q2;
            if (instr_take)
            begin
               next_kind = in_kind;
               next_held_instr = instr;
               next_held_pc = pc_incr;
               next_held_zero = zero_flag;
               if (in_kind == rbd_pkg::K_BSF)
               begin
                  // Read in Q2 of the same cycle
                  next_data_addr = in_addr;
                  next_data_rd = 1'b1;
               end
            end
            else
            begin
               // Flush cycle or no word: nothing executes
               next_kind = rbd_pkg::K_NONE;
            end
         end
         rbd_pkg::PH_Q2:
         begin
            next_phase = rbd_pkg::PH_Q3;
            if (kind == rbd_pkg::K_BSF)
            begin
               next_read_value = data_rdata;
            end
         end
         rbd_pkg::PH_Q3:
         begin
            next_phase = rbd_pkg::PH_Q4;
            case (kind)
               rbd_pkg::K_BRA:
               begin
                  next_program_counter_target = branch_target(held_pc,
                     held_instr[rbd_pkg::OFF_W-1:0]);
                  next_program_counter_load = 1'b1;
                  next_flush_pending = 1'b1;
               end
               rbd_pkg::K_BNZ:
               begin
                  // Untaken leaves the counter alone and costs one cycle
                  if (!held_zero)
                  begin
                     next_program_counter_target = branch_target(held_pc,
                        widen_off(held_instr[7:0]));
                     next_program_counter_load = 1'b1;
                     next_flush_pending = 1'b1;
                  end
               end
               rbd_pkg::K_BSF:
               begin
                  // Write back to the address still held from Q2
                  next_data_wdata = read_value | set_mask;
                  next_data_wr = 1'b1;
               end
               default:
               begin
                  next_flush_pending = flush_pending;
               end
            endcase
         end
         rbd_pkg::PH_Q4:
         begin
            next_phase = rbd_pkg::PH_Q1;
            // Flush covers exactly the next instruction cycle
            next_flush_active = flush_pending;
            next_flush_pending = 1'b0;
         end
         default:
         begin
            next_phase = rbd_pkg::PH_Q1;
            next_kind = rbd_pkg::K_NONE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= rbd_pkg::PH_Q1;
         kind <= rbd_pkg::K_NONE;
         held_instr <= rbd_pkg::INSTR_RESET;
         held_pc <= rbd_pkg::PC_RESET;
         held_zero <= 1'b0;
         flush_pending <= 1'b0;
         read_value <= rbd_pkg::DATA_RESET;
         program_counter_target <= rbd_pkg::PC_RESET;
         program_counter_load <= 1'b0;
         flush_active <= 1'b0;
         data_addr <= rbd_pkg::ADDR_RESET;
         data_rd <= 1'b0;
         data_wr <= 1'b0;
         data_wdata <= rbd_pkg::DATA_RESET;
      end
      else
      begin
         phase <= next_phase;
         kind <= next_kind;
         held_instr <= next_held_instr;
         held_pc <= next_held_pc;
         held_zero <= next_held_zero;
         flush_pending <= next_flush_pending;
         read_value <= next_read_value;
         program_counter_target <= next_program_counter_target;
         program_counter_load <= next_program_counter_load;
         flush_active <= next_flush_active;
         data_addr <= next_data_addr;
         data_rd <= next_data_rd;
         data_wr <= next_data_wr;
         data_wdata <= next_data_wdata;
      end
   end

endmodule

// File: verification/rbd_regfile.sv
// Register file model answering the execute unit's read and write pulses
`timescale 1ns/1ps
module rbd_regfile
(
   input wire logic clock,
   input wire logic [rbd_pkg::DA_W-1:0] data_addr,
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   output logic [7:0] data_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last = 8'h00;

   // Known start pattern so the bench can predict every read
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i * 3);
   end

   // Idle bus shows the inverse of the last read, never a stale match
   assign data_rdata = data_rd ? mem[data_addr] : ~last;

   // Writes land at the rising edge
   always @(posedge clock)
   begin
      if (data_wr)
         mem[data_addr] <= data_wdata;
      if (data_rd)
         last <= mem[data_addr];
   end
endmodule

// File: verification/rbd_check_sva.sv
// Concurrent checks on the execute unit ports
`timescale 1ns/1ps
module rbd_check
(
   input logic clock,
   input logic rst_n,
   input logic [15:0] instr,
   input logic [rbd_pkg::PC_W-1:0] pc_incr,
   input logic zero_flag,
   input logic ext_set_enable,
   input logic [rbd_pkg::BANK_W-1:0] bank_select_register,
   input logic [rbd_pkg::DA_W-1:0] literal_base,
   input logic [7:0] data_rdata,
   input logic instr_take,
   input logic cycle_start,
   input logic [rbd_pkg::PC_W-1:0] program_counter_target,
   input logic program_counter_load,
   input logic flush_active,
   input logic [rbd_pkg::DA_W-1:0] data_addr,
   input logic data_rd,
   input logic data_wr,
   input logic [7:0] data_wdata
);
   logic [rbd_pkg::PC_W-1:0] bra_tgt;
   logic [rbd_pkg::PC_W-1:0] bnz_tgt;
   logic [rbd_pkg::DA_W-1:0] want_addr;

   // Own decode of the word, so a shared slip cannot hide
   assign bra_tgt = pc_incr + {{9{instr[10]}}, instr[10:0], 1'b0};
   assign bnz_tgt = pc_incr + {{12{instr[7]}}, instr[7:0], 1'b0};
   assign want_addr = instr[8] ? {bank_select_register, instr[7:0]} :
      (instr[7:0] > 8'h5f) ? {4'hf, instr[7:0]} :
      ext_set_enable ? literal_base + {4'h0, instr[7:0]} : {4'h0, instr[7:0]};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Branches
   bra_load_a: assert property (
      instr_take && instr[15:11] == 5'b11010 |-> ##3 program_counter_load
      && program_counter_target == $past(bra_tgt, 3)) else $error("branch target wrong");
   bnz_jump_a: assert property (
      instr_take && instr[15:8] == 8'he1 && !zero_flag |-> ##3 program_counter_load
      && program_counter_target == $past(bnz_tgt, 3)) else $error("taken branch wrong");
   bnz_stay_a: assert property (
      instr_take && instr[15:8] == 8'he1 && zero_flag
      |=> (!program_counter_load && !flush_active) [*6]) else $error("untaken branch moved");
   flush_len_a: assert property (
      program_counter_load |=> flush_active [*4] ##1 !flush_active) else $error("flush length");
   flush_refuse_a: assert property (
      flush_active |-> !instr_take) else $error("word taken in flush");
   // Flush must open on a cycle boundary, right after a counter load
   flush_align_a: assert property (
      $rose(flush_active) |-> cycle_start && $past(program_counter_load)) else $error("flush start");
   phase_count_a: assert property (
      cycle_start |=> !cycle_start [*3] ##1 cycle_start) else $error("phase count");

   // ==========================================================
   // Single bit set
   bit_write_a: assert property (
      instr_take && instr[15:12] == 4'h8 |=> data_rd ##2 data_wr && data_wdata ==
      ($past(data_rdata, 2) | (8'h01 << $past(instr[11:9], 3)))) else $error("bit set data");
   bit_addr_a: assert property (
      instr_take && instr[15:12] == 4'h8 |=> data_addr == $past(want_addr)
      ##2 data_addr == $past(data_addr, 2)) else $error("bit set address");
endmodule

bind rbd_exec rbd_check chk (.*);

// File: verification/relative_branch_and_bit_set_decode_test.sv
// Self-checking bench for the branch and bit set execute unit
`timescale 1ns/1ps
module relative_branch_and_bit_set_decode_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [20:0] pc_incr = 21'h000000;
   logic zero_flag = 1'b0;
   logic ext_set_enable = 1'b0;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] literal_base = 12'h000;
   logic [7:0] data_rdata, data_wdata;
   logic instr_take, cycle_start, program_counter_load, flush_active, data_rd, data_wr;
   logic [20:0] program_counter_target;
   logic [11:0] data_addr;
   logic [7:0] ref_mem [4096];
   logic flush_due = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   int seed = 53;
   logic [15:0] words [9] = '{16'hd3ff, 16'hd400, 16'he180, 16'h8e5f, 16'h8060,
      16'h81ff, 16'hd800, 16'he205, 16'hf123};

   initial forever #20 clock = ~clock;
   rbd_exec dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
      .pc_incr(pc_incr), .zero_flag(zero_flag), .ext_set_enable(ext_set_enable),
      .bank_select_register(bank_select_register), .literal_base(literal_base),
      .data_rdata(data_rdata), .instr_take(instr_take), .cycle_start(cycle_start),
      .program_counter_target(program_counter_target),
      .program_counter_load(program_counter_load), .flush_active(flush_active),
      .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata));
   rbd_regfile regs (.clock(clock), .data_addr(data_addr), .data_rd(data_rd),
      .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));

   // ==========================================================
   // Compare and close
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================================
   // One instruction cycle: drive in Q1, check in Q1, Q2 and Q4
   task automatic issue(input logic [15:0] w, input logic vld);
      logic take, single_bit_set, jump;
      logic [11:0] a;
      logic [7:0] v;
      logic [20:0] t;
      @(posedge clock);
      instr <= w;
      instr_valid <= vld;
      pc_incr <= 21'($random(seed));
      zero_flag <= 1'($random(seed));
      ext_set_enable <= 1'($random(seed));
      bank_select_register <= 4'($random(seed));
      literal_base <= 12'($random(seed));
      @(negedge clock);
      // A word counts only when valid and outside the flush cycle
      take = vld && !flush_due;
      single_bit_set = take && w[15:12] == 4'h8;
      jump = take && (w[15:11] == 5'b11010 || (w[15:8] == 8'he1 && !zero_flag));
      a = w[8] ? {bank_select_register, w[7:0]} : (w[7:0] > 8'h5f) ? {4'hf, w[7:0]} :
         ext_set_enable ? literal_base + {4'h0, w[7:0]} : {4'h0, w[7:0]};
      v = ref_mem[a] | (8'h01 << w[11:9]);
      // Sum held to 21 bits so a backward branch wraps like the counter
      t = pc_incr + (w[15:12] == 4'hd ? {{9{w[10]}}, w[10:0], 1'b0} :
         {{12{w[7]}}, w[7:0], 1'b0});
      cmp("take", 32'(take), 32'(instr_take));
      cmp("flush", 32'(flush_due), 32'(flush_active));
      @(negedge clock);
      cmp("read", 32'(single_bit_set), 32'(data_rd));
      if (single_bit_set)
         cmp("addr", 32'(a), 32'(data_addr));
      repeat (2) @(negedge clock);
      cmp("load", 32'(jump), 32'(program_counter_load));
      cmp("write", 32'(single_bit_set), 32'(data_wr));
      if (jump)
         cmp("target", 32'(t), 32'(program_counter_target));
      if (single_bit_set)
      begin
         cmp("wdata", 32'(v), 32'(data_wdata));
         ref_mem[a] = v;
      end
      flush_due = jump;
   endtask

   // ==========================================================
   // Directed corner words, then a random stream
   initial
   begin
      logic [15:0] w;
      logic [1:0] k;
      for (int i = 0; i < 4096; i++)
         ref_mem[i] = 8'(i * 3);
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      foreach (words[i])
      begin
         // Idle word after a jump so no directed word is lost to a flush
         if (flush_due)
            issue(16'h0000, 1'b1);
         issue(words[i], 1'b1);
      end
      // Mid-run reset: registered outputs clear, phase restarts at Q1
      @(posedge clock);
      rst_n <= 1'b0;
      @(negedge clock);
      cmp("rst_start", 32'h1, 32'(cycle_start));
      cmp("rst_load", 32'h0, 32'(program_counter_load));
      cmp("rst_flush", 32'h0, 32'(flush_active));
      cmp("rst_target", 32'h0, 32'(program_counter_target));
      cmp("rst_wr", 32'h0, 32'(data_wr));
      cmp("rst_addr", 32'h0, 32'(data_addr));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      flush_due = 1'b0;
      repeat (3) @(posedge clock);
      repeat (400)
      begin
         w = 16'($random(seed));
         k = 2'($random(seed));
         if (k == 2'h0)
            w[15:11] = 5'b11010;
         else if (k == 2'h1)
            w[15:12] = 4'h8;
         else if (k == 2'h2)
            w[15:8] = 8'he1;
         // About one word in eight arrives without valid
         issue(w, 3'($random(seed)) != 3'h0);
      end
      stop_test();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule
